//--- lsfm_pkg.sv
// constants and carrier types for the lvds sync fifo monitor block
// assumes a single 100 MHz dac clock domain; the data strobe arrives as a sampled enable
package lsfm_pkg;

    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int DATA_W = 14;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int SIG_W = 32;
    localparam int FRAC_W = 12;
    localparam int DLY_W = 4;
    localparam int DIV_W = 6;
    localparam int FIFO_EXTRA_LAT = 4;
    localparam int CLK_HZ = 100_000_000;
    localparam int CTRL_CLK_MAX_HZ = 10_000_000;
    localparam logic [3:0] PREDIV_BASE = 4'h4;
    localparam logic [3:0] FILTER_MAX = 4'hC;
    localparam logic [1:0] PHASE_STEP_SHIFT = 2'h1;
    localparam logic [15:0] IDLE_UNSIGNED = 16'h0000;
    localparam logic [15:0] IDLE_TWOS = 16'h2000;

    // ------------------------------------------------------------
    // fifo phase status codes
    // ------------------------------------------------------------
    localparam logic [2:0] PH_CRIT_LO = 3'h0;
    localparam logic [2:0] PH_WARN_LO = 3'h1;
    localparam logic [2:0] PH_OPT_LO = 3'h3;
    localparam logic [2:0] PH_OPT_HI = 3'h4;
    localparam logic [2:0] PH_WARN_HI = 3'h6;
    localparam logic [2:0] PH_CRIT_HI = 3'h7;

    // ------------------------------------------------------------
    // signature select codes
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_LVDS_P1 = 2'h0;
    localparam logic [1:0] SEL_LVDS_P2 = 2'h1;
    localparam logic [1:0] SEL_SYNC_P1 = 2'h2;
    localparam logic [1:0] SEL_SYNC_P2 = 2'h3;

    typedef struct packed {
        logic surveillance_enable;
        logic auto_update;
        logic interrupt_enable;
        logic [1:0] eye_drift_threshold;
        logic [3:0] eye_filter_length;
        logic [3:0] sample_delay_init;
    } lsfm_eye_cfg_t;

    typedef struct packed {
        logic surveillance_enable;
        logic auto_update;
        logic interrupt_enable;
        logic sync_threshold_bit;
        logic [3:0] sync_filter_field;
    } lsfm_sync_cfg_t;

    typedef struct packed {
        logic clear;
        logic lvds_en;
        logic sync_en;
        logic [1:0] sel;
    } lsfm_bist_cfg_t;

    typedef struct packed {
        logic eye_irq_flag;
        logic sync_irq_flag;
        logic sync_logic_error_flag;
        logic [2:0] fifo_phase_status;
    } lsfm_status_t;

endpackage

//--- lsfm_sig_gen.sv
// one 32-bit lfsr signature generator for a single data phase
// assumes words arrive as enabled samples on the dac clock
module lsfm_sig_gen #(
    parameter int DW = 14,
    parameter int SW = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic clear,
    input wire logic enable,
    input wire logic word_valid,
    input wire logic [DW-1:0] word,
    output logic [SW-1:0] signature
);

    logic [SW-1:0] next_signature;

    // ------------------------------------------------------------
    // signature update, zero words leave it unchanged
    // ------------------------------------------------------------
    always_comb begin
        next_signature = signature;
        if (clear) begin
            next_signature = '0;
        end else if (enable && word_valid && (word != '0)) begin
            for (int i = 0; i < SW; i++) begin
                if (i == 0) begin
                    next_signature[i] = ~(signature[SW-1] ^ word[0]);
                end else if (i < DW) begin
                    next_signature[i] = ~(signature[i-1] ^ word[i]);
                end else begin
                    next_signature[i] = signature[i-1];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            signature <= '0;
        end else if (ce) begin
            signature <= next_signature;
        end
    end

endmodule

//--- lsfm_top.sv
// data input path: eye monitor, synchronizing fifo with phase control, bypass and bist
// assumes one dac clock; data_sampling_strobe marks each sampled input word
module lsfm_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire lsfm_pkg::lsfm_eye_cfg_t eye_cfg,
    input wire logic meas_valid,
    input wire logic [3:0] measured_hold_delay,
    input wire logic [3:0] measured_setup_delay,
    input wire lsfm_pkg::lsfm_sync_cfg_t sync_cfg,
    input wire logic fifo_mode,
    input wire logic [1:0] phase_offset,
    input wire logic [3:0] controller_clock_predivider,
    input wire logic data_sampling_strobe,
    input wire logic [lsfm_pkg::DATA_W-1:0] data_in,
    input wire lsfm_pkg::lsfm_bist_cfg_t bist_cfg,
    output logic [lsfm_pkg::DATA_W-1:0] dac_data,
    output logic [3:0] sample_delay,
    output logic [1:0] phase_offset_applied,
    output lsfm_pkg::lsfm_status_t status,
    output logic irq,
    output logic [lsfm_pkg::SIG_W-1:0] signature
);

    localparam int EACC_W = lsfm_pkg::FRAC_W + 6;
    localparam int SACC_W = lsfm_pkg::FRAC_W + 5;
    localparam int DW = lsfm_pkg::DATA_W;
    localparam int PW = lsfm_pkg::PTR_W;

    // ------------------------------------------------------------
    // controller clock tick
    // ------------------------------------------------------------
    logic [lsfm_pkg::DIV_W-1:0] div_cnt, next_div_cnt;
    logic tick, next_tick;
    logic [lsfm_pkg::DIV_W-1:0] div_len;

    // divide by 2 * (predivider + 4)
    always_comb begin
        div_len = {5'(controller_clock_predivider) + 5'(lsfm_pkg::PREDIV_BASE), 1'b0};
        next_tick = 1'b0;
        next_div_cnt = div_cnt + 1'b1;
        if (div_cnt >= div_len - 1'b1) begin
            next_div_cnt = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end

    // ------------------------------------------------------------
    // eye monitor
    // ------------------------------------------------------------
    logic meas_pending, next_meas_pending;
    logic signed [EACC_W-1:0] eye_new, next_eye_new;
    logic signed [EACC_W-1:0] eye_acc, next_eye_acc;
    logic [3:0] next_sample_delay;
    logic eye_flag, next_eye_flag;
    logic eye_ie_low, next_eye_ie_low;
    logic signed [EACC_W:0] eye_delta;
    logic signed [EACC_W-1:0] eye_int;
    logic [EACC_W-1:0] eye_mag;
    logic signed [5:0] sd_sum;
    logic eye_auto;
    logic eye_viol;

    // filtered eye position, auto update of the sample delay
    always_comb begin
        eye_auto = eye_cfg.surveillance_enable && eye_cfg.auto_update;
        next_meas_pending = meas_pending | meas_valid;
        next_eye_new = eye_new;
        if (meas_valid) begin
            // (hold - setup) / 2 in fixed point
            next_eye_new = EACC_W'(($signed({2'b00, measured_hold_delay}) - $signed({2'b00, measured_setup_delay}))
                           <<< (lsfm_pkg::FRAC_W - 1));
        end
        eye_delta = (EACC_W+1)'(eye_new) - (EACC_W+1)'(eye_acc);
        eye_int = eye_acc >>> lsfm_pkg::FRAC_W;
        eye_mag = eye_int[EACC_W-1] ? EACC_W'(-eye_int) : EACC_W'(eye_int);
        eye_viol = eye_mag > EACC_W'(eye_cfg.eye_drift_threshold);
        sd_sum = $signed({2'b00, sample_delay}) + 6'(eye_int);
        next_eye_acc = eye_acc;
        next_sample_delay = sample_delay;
        next_eye_flag = eye_flag;
        next_eye_ie_low = eye_ie_low;
        if (!eye_cfg.surveillance_enable) begin
            next_eye_acc = '0;
            next_sample_delay = eye_cfg.sample_delay_init;
        end else if (tick && meas_pending && !eye_flag) begin
            next_meas_pending = meas_valid;
            next_eye_acc = EACC_W'(eye_acc + EACC_W'(eye_delta >>> eye_cfg.eye_filter_length));
        end
        if (eye_cfg.surveillance_enable && tick && !eye_flag && eye_viol) begin
            if (eye_auto) begin
                // re-centre the strobe and restart the average
                next_sample_delay = sd_sum[5] ? 4'h0 : (sd_sum > 6'sd15 ? 4'hF : sd_sum[3:0]);
                next_eye_acc = '0;
            end else begin
                next_eye_flag = 1'b1;
            end
        end
        // clear after a whole controller cycle with enable low, set wins
        if (tick) begin
            next_eye_ie_low = !eye_cfg.interrupt_enable;
            if (eye_ie_low && !eye_cfg.interrupt_enable && !(next_eye_flag && !eye_flag)) begin
                next_eye_flag = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meas_pending <= 1'b0;
            eye_new <= '0;
            eye_acc <= '0;
            sample_delay <= '0;
            eye_flag <= 1'b0;
            eye_ie_low <= 1'b0;
        end else if (ce) begin
            meas_pending <= next_meas_pending;
            eye_new <= next_eye_new;
            eye_acc <= next_eye_acc;
            sample_delay <= next_sample_delay;
            eye_flag <= next_eye_flag;
            eye_ie_low <= next_eye_ie_low;
        end
    end

    // ------------------------------------------------------------
    // synchronizing fifo
    // ------------------------------------------------------------
    logic [DW-1:0] mem [lsfm_pkg::FIFO_DEPTH];
    logic [PW-1:0] wr_ptr, next_wr_ptr;
    logic [PW-1:0] rd_cnt, next_rd_cnt;
    logic [PW-1:0] rd_addr;
    logic [PW-1:0] phase_meas, next_phase_meas;
    logic sync_err, next_sync_err;
    logic [DW-1:0] in_q, next_in_q;
    logic [DW-1:0] pipe [lsfm_pkg::FIFO_EXTRA_LAT];
    logic [DW-1:0] next_dac_data;
    logic [1:0] auto_ofs;
    logic lvds_phase, next_lvds_phase;
    logic sync_phase, next_sync_phase;

    // pointers, phase capture and crossing check
    always_comb begin
        rd_addr = rd_cnt + PW'({phase_offset + auto_ofs, 1'b0});
        next_wr_ptr = wr_ptr;
        next_rd_cnt = rd_cnt;
        next_phase_meas = phase_meas;
        next_sync_err = sync_err;
        next_in_q = in_q;
        next_lvds_phase = lvds_phase;
        next_sync_phase = ~sync_phase;
        if (data_sampling_strobe) begin
            next_in_q = data_in;
            next_lvds_phase = ~lvds_phase;
        end
        if (!fifo_mode) begin
            next_wr_ptr = '0;
            next_rd_cnt = '0;
            next_sync_err = 1'b0;
        end else begin
            next_rd_cnt = rd_cnt + 1'b1;
            if (data_sampling_strobe) begin
                next_wr_ptr = wr_ptr + 1'b1;
                if (wr_ptr == rd_addr) begin
                    next_sync_err = 1'b1;
                end
            end
            if (rd_cnt == '0) begin
                next_phase_meas = wr_ptr - rd_addr;
            end
        end
        next_dac_data = fifo_mode ? pipe[lsfm_pkg::FIFO_EXTRA_LAT-1] : in_q;
    end

    always_ff @(posedge clk) begin
        if (ce && fifo_mode && data_sampling_strobe) begin
            mem[wr_ptr] <= data_in;
        end
    end

    // read register plus fixed pipeline
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < lsfm_pkg::FIFO_EXTRA_LAT; i++) begin
                pipe[i] <= '0;
            end
        end else if (ce) begin
            pipe[0] <= mem[rd_addr];
            for (int i = 1; i < lsfm_pkg::FIFO_EXTRA_LAT; i++) begin
                pipe[i] <= pipe[i-1];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_cnt <= '0;
            phase_meas <= '0;
            sync_err <= 1'b0;
            in_q <= '0;
            dac_data <= '0;
            lvds_phase <= 1'b0;
            sync_phase <= 1'b0;
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            rd_cnt <= next_rd_cnt;
            phase_meas <= next_phase_meas;
            sync_err <= next_sync_err;
            in_q <= next_in_q;
            dac_data <= next_dac_data;
            lvds_phase <= next_lvds_phase;
            sync_phase <= next_sync_phase;
        end
    end

    // ------------------------------------------------------------
    // sync controller
    // ------------------------------------------------------------
    logic [SACC_W-1:0] sync_acc, next_sync_acc;
    logic [1:0] next_auto_ofs;
    logic sync_flag, next_sync_flag;
    logic sync_ie_low, next_sync_ie_low;
    logic signed [SACC_W:0] sync_delta;
    logic [3:0] sflt;
    logic [2:0] sync_int;
    logic sync_viol;
    logic sync_run;

    // filtered phase status and threshold check
    always_comb begin
        sflt = (sync_cfg.sync_filter_field > lsfm_pkg::FILTER_MAX) ? lsfm_pkg::FILTER_MAX
               : sync_cfg.sync_filter_field;
        sync_delta = $signed({2'b00, phase_meas, {lsfm_pkg::FRAC_W{1'b0}}}) - $signed({1'b0, sync_acc});
        sync_int = sync_acc[lsfm_pkg::FRAC_W +: PW];
        sync_viol = (sync_int == lsfm_pkg::PH_CRIT_LO) || (sync_int == lsfm_pkg::PH_CRIT_HI)
                    || (sync_cfg.sync_threshold_bit
                        && ((sync_int == lsfm_pkg::PH_WARN_LO) || (sync_int == lsfm_pkg::PH_WARN_HI)));
        sync_run = sync_cfg.surveillance_enable && fifo_mode;
        next_sync_acc = sync_acc;
        next_auto_ofs = auto_ofs;
        next_sync_flag = sync_flag;
        next_sync_ie_low = sync_ie_low;
        if (!sync_run) begin
            next_sync_acc = SACC_W'({phase_meas, {lsfm_pkg::FRAC_W{1'b0}}});
        end else if (tick && !sync_flag) begin
            next_sync_acc = SACC_W'($signed({1'b0, sync_acc}) + (sync_delta >>> sflt));
            if (sync_viol) begin
                if (sync_cfg.auto_update) begin
                    // low status: move the read pointer back, high: forward
                    next_auto_ofs = (sync_int <= lsfm_pkg::PH_OPT_LO) ? auto_ofs - 1'b1 : auto_ofs + 1'b1;
                    next_sync_acc = SACC_W'({lsfm_pkg::PH_OPT_HI, {lsfm_pkg::FRAC_W{1'b0}}});
                end else begin
                    next_sync_flag = 1'b1;
                end
            end
        end
        if (tick) begin
            next_sync_ie_low = !sync_cfg.interrupt_enable;
            if (sync_ie_low && !sync_cfg.interrupt_enable && !(next_sync_flag && !sync_flag)) begin
                next_sync_flag = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_acc <= '0;
            auto_ofs <= '0;
            sync_flag <= 1'b0;
            sync_ie_low <= 1'b0;
            phase_offset_applied <= '0;
            status <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            sync_acc <= next_sync_acc;
            auto_ofs <= next_auto_ofs;
            sync_flag <= next_sync_flag;
            sync_ie_low <= next_sync_ie_low;
            phase_offset_applied <= phase_offset + next_auto_ofs;
            status <= '{eye_irq_flag: next_eye_flag, sync_irq_flag: next_sync_flag,
                        sync_logic_error_flag: next_sync_err, fifo_phase_status: next_phase_meas};
            irq <= (next_eye_flag && eye_cfg.interrupt_enable)
                   || (next_sync_flag && sync_cfg.interrupt_enable);
        end
    end

    // ------------------------------------------------------------
    // signature generators: lvds stage and sync stage, two phases each
    // ------------------------------------------------------------
    logic [lsfm_pkg::SIG_W-1:0] sig [4];
    logic [3:0] sig_en;
    logic [3:0] sig_valid;
    logic [DW-1:0] sig_word [4];

    always_comb begin
        sig_en = {bist_cfg.sync_en, bist_cfg.sync_en, bist_cfg.lvds_en, bist_cfg.lvds_en};
        sig_valid[lsfm_pkg::SEL_LVDS_P1] = data_sampling_strobe && !lvds_phase;
        sig_valid[lsfm_pkg::SEL_LVDS_P2] = data_sampling_strobe && lvds_phase;
        sig_valid[lsfm_pkg::SEL_SYNC_P1] = !sync_phase;
        sig_valid[lsfm_pkg::SEL_SYNC_P2] = sync_phase;
        sig_word[lsfm_pkg::SEL_LVDS_P1] = data_in;
        sig_word[lsfm_pkg::SEL_LVDS_P2] = data_in;
        sig_word[lsfm_pkg::SEL_SYNC_P1] = next_dac_data;
        sig_word[lsfm_pkg::SEL_SYNC_P2] = next_dac_data;
    end

    for (genvar g = 0; g < 4; g++) begin : g_sig
        lsfm_sig_gen #(
            .DW(DW),
            .SW(lsfm_pkg::SIG_W)
        ) u_sig (
            .clk(clk),
            .reset_n(reset_n),
            .ce(ce),
            .clear(bist_cfg.clear),
            .enable(sig_en[g]),
            .word_valid(sig_valid[g]),
            .word(sig_word[g]),
            .signature(sig[g])
        );
    end

    // selected signature, registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            signature <= '0;
        end else if (ce) begin
            signature <= sig[bist_cfg.sel];
        end
    end

endmodule

//--- lsfm_top_asserts.sv
// checker for the lsfm_top port behaviour
// assumes it is bound onto lsfm_top; one clock domain
module lsfm_top_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire lsfm_pkg::lsfm_eye_cfg_t eye_cfg,
    input wire lsfm_pkg::lsfm_sync_cfg_t sync_cfg,
    input wire logic fifo_mode,
    input wire logic data_sampling_strobe,
    input wire logic [lsfm_pkg::DATA_W-1:0] data_in,
    input wire lsfm_pkg::lsfm_bist_cfg_t bist_cfg,
    input wire logic [lsfm_pkg::DATA_W-1:0] dac_data,
    input wire logic [3:0] sample_delay,
    input wire lsfm_pkg::lsfm_status_t status,
    input wire logic irq,
    input wire logic [lsfm_pkg::SIG_W-1:0] signature
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // properties
    // ------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // word taken in bypass, then one more running cycle
    sequence s_byp_take;
        ce && data_sampling_strobe && !fifo_mode ##1 ce && !fifo_mode;
    endsequence
    // data path, irq and sample delay relations
    AST_BYPASS: assert property (s_byp_take |=> dac_data == $past(data_in, 2))
        else $error("bypass word late or wrong");
    AST_IRQ: assert property ($past(ce) && $stable(status) && $stable(eye_cfg) && $stable(sync_cfg)
        |-> irq == (status.eye_irq_flag && eye_cfg.interrupt_enable || status.sync_irq_flag && sync_cfg.interrupt_enable))
        else $error("irq not the enabled flags");
    AST_SD_INIT: assert property ((ce && !eye_cfg.surveillance_enable && $stable(eye_cfg)) [*2]
        |-> sample_delay == eye_cfg.sample_delay_init) else $error("sample delay not the initial value");
    AST_SD_HOLD: assert property ($changed(sample_delay)
        |-> $past(eye_cfg.auto_update || !eye_cfg.surveillance_enable)) else $error("sample delay moved outside auto");
    // interrupt flag set and clear, sync error flag hold and signature clear conditions
    AST_EYE_FLAG: assert property ($rose(status.eye_irq_flag)
        |-> $past(eye_cfg.surveillance_enable && !eye_cfg.auto_update)) else $error("eye flag outside surveillance");
    AST_SYNC_FLAG: assert property ($rose(status.sync_irq_flag)
        |-> $past(sync_cfg.surveillance_enable && fifo_mode && !sync_cfg.auto_update)) else $error("sync flag wrong mode");
    AST_EYE_CLR: assert property ($fell(status.eye_irq_flag) |-> $past(!eye_cfg.interrupt_enable))
        else $error("eye flag cleared while enabled");
    AST_ERR_STICKY: assert property (fifo_mode [*2] ##0 status.sync_logic_error_flag
        |=> status.sync_logic_error_flag) else $error("sync error flag dropped in fifo mode");
    AST_BIST_CLR: assert property ((ce && bist_cfg.clear) [*3] |-> signature == 32'h0)
        else $error("signature not cleared");
endmodule
bind lsfm_top lsfm_top_asserts u_lsfm_top_asserts (.clk, .reset_n, .ce, .eye_cfg, .sync_cfg, .fifo_mode,
    .data_sampling_strobe, .data_in, .bist_cfg, .dac_data, .sample_delay, .status, .irq, .signature);

//--- lsfm_src_model.sv
// data source model: one strobe and one 14-bit word per dac clock
// assumes the bench raises run after reset and vec while a vector is sent
module lsfm_src_model (
    input wire logic clk,
    input wire logic run,
    input wire logic vec,
    output logic strobe,
    output logic [lsfm_pkg::DATA_W-1:0] data,
    output int cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // word source
    // ------
    initial begin
        strobe = 1'b0;
        data = 14'h0;
        cnt = 0;
    end
    // new word each falling edge; idle code between vectors
    always @(negedge clk) begin
        strobe <= run;
        cnt <= run ? cnt + 1 : cnt;
        if (!run) begin
            data <= ~data; // released lines keep no stale value
        end else if (vec) begin
            data <= 14'(cnt * 32'h2A5 + 32'h13);
        end else begin
            data <= lsfm_pkg::IDLE_UNSIGNED[13:0];
        end
    end
endmodule

//--- tb_top.sv
// self-checking bench for lsfm_top: bist, eye and sync controllers
// assumes 100 MHz clk, ce high except for the 40-cycle frozen check, controller tick every 10 cycles
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic run = 1'b0;
    logic vec = 1'b0;
    logic ce = 1'b1;
    logic data_sampling_strobe;
    logic meas_valid = 1'b0;
    logic fifo_mode = 1'b0;
    logic [1:0] phase_offset = 2'h0;
    logic [3:0] measured_hold_delay = 4'h8;
    logic [3:0] measured_setup_delay = 4'h0;
    logic [lsfm_pkg::DATA_W-1:0] data_in;
    logic [lsfm_pkg::DATA_W-1:0] dac_data;
    logic [3:0] sample_delay;
    logic [1:0] phase_offset_applied;
    logic irq;
    logic [31:0] signature;
    lsfm_pkg::lsfm_eye_cfg_t eye_cfg = 13'h0004;
    lsfm_pkg::lsfm_sync_cfg_t sync_cfg = 8'h00;
    lsfm_pkg::lsfm_bist_cfg_t bist_cfg = 5'h00;
    lsfm_pkg::lsfm_status_t status;
    int mismatches = 0;
    int tests_run = 0;
    int src_cnt;
    logic [31:0] exp_sig [2];
    logic [2:0] s0;
    logic [2:0] wide;

    // ------
    // clock, source and design
    // ------
    always #5 clk = ~clk;
    lsfm_src_model u_lsfm_src_model (.clk, .run, .vec, .strobe(data_sampling_strobe), .data(data_in), .cnt(src_cnt));
    lsfm_top u_lsfm_top (.clk, .reset_n, .ce, .eye_cfg, .meas_valid, .measured_hold_delay,
        .measured_setup_delay, .sync_cfg, .fifo_mode, .phase_offset, .controller_clock_predivider(4'h1),
        .data_sampling_strobe, .data_in, .bist_cfg, .dac_data, .sample_delay, .phase_offset_applied, .status,
        .irq, .signature);

    // ------
    // helpers
    // ------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait for an interrupt flag level
    task automatic wait_flag(input bit sync, input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && (sync ? status.sync_irq_flag : status.eye_irq_flag) !== lvl; i++) cyc(1);
        if (i == lim) begin
            chk("flag wait", 1'b1, 1'b0);
            finish_test();
        end
    endtask
    // signature step of one generator; zero words leave it
    function automatic logic [31:0] lfsr(input logic [31:0] s, input logic [13:0] w);
        return (w == 14'h0) ? s : ({s[30:0], s[31]} ^ {18'h0, ~w});
    endfunction

    // ------
    // tests
    // ------
    initial begin
        cyc(2);
        reset_n = 1'b1;
        run <= 1'b1;
        cyc(2);
        chk("sample_delay", 4'h4, sample_delay);
        // bist: clear, send a vector, then idle and read all four
        bist_cfg = 5'h1C;
        cyc(10);
        bist_cfg = 5'h0C;
        exp_sig = '{32'h0, 32'h0};
        cyc(1);
        if (src_cnt[0] == 1'b0) cyc(1);
        vec <= 1'b1;
        for (int k = 1; k <= 20; k++) exp_sig[(src_cnt + k) % 2] = lfsr(exp_sig[(src_cnt + k) % 2],
            14'((src_cnt + k) * 32'h2A5 + 32'h13));
        cyc(20);
        chk("dac_data", 32'(14'((src_cnt - 2) * 32'h2A5 + 32'h13)), dac_data);
        vec <= 1'b0;
        cyc(10);
        for (int s = 0; s < 4; s++) begin
            bist_cfg.sel = 2'(s);
            cyc(3);
            chk("signature", exp_sig[s % 2], signature);
        end
        $display("test bist done");
        // eye surveillance: long filter stays quiet, short filter trips
        meas_valid = 1'b1;
        eye_cfg = '{1'b1, 1'b0, 1'b1, 2'h1, 4'hC, 4'h4};
        cyc(100);
        chk("eye flag", 1'b0, status.eye_irq_flag);
        eye_cfg.eye_filter_length = 4'h0;
        // clock enable low: nothing may move
        ce = 1'b0;
        cyc(40);
        chk("frozen eye flag", 1'b0, status.eye_irq_flag);
        ce = 1'b1;
        wait_flag(1'b0, 1'b1, 200);
        cyc(2);
        chk("irq", 1'b1, irq);
        chk("sample_delay", 4'h4, sample_delay);
        eye_cfg = '{1'b0, 1'b0, 1'b0, 2'h1, 4'h0, 4'h4};
        cyc(2);
        chk("irq", 1'b0, irq);
        wait_flag(1'b0, 1'b0, 60);
        // eye auto: delay rewritten, no flag; auto alone does nothing
        eye_cfg = '{1'b1, 1'b1, 1'b0, 2'h1, 4'h0, 4'h4};
        cyc(100);
        chk("sample_delay", 4'hF, sample_delay);
        chk("eye flag", 1'b0, status.eye_irq_flag);
        eye_cfg.surveillance_enable = 1'b0;
        cyc(3);
        chk("sample_delay", 4'h4, sample_delay);
        meas_valid = 1'b0;
        $display("test eye done");
        // fifo phase: one offset step lowers the status by two
        fifo_mode = 1'b1;
        cyc(50);
        s0 = status.fifo_phase_status;
        chk("sync error", s0 == lsfm_pkg::PH_CRIT_LO, status.sync_logic_error_flag);
        phase_offset = 2'h1;
        cyc(50);
        chk("phase status", 3'(s0 - 3'h2), status.fifo_phase_status);
        wide = s0[0] ? 3'h1 : 3'h6;
        phase_offset = 2'(3'(s0 - wide) >> 1);
        cyc(50);
        chk("phase status", wide, status.fifo_phase_status);
        chk("applied offset", phase_offset, phase_offset_applied);
        // sync surveillance: narrow threshold quiet, wide threshold trips
        sync_cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 4'h0};
        cyc(1);
        sync_cfg.interrupt_enable = 1'b1;
        cyc(100);
        chk("sync flag", 1'b0, status.sync_irq_flag);
        sync_cfg.sync_threshold_bit = 1'b1;
        wait_flag(1'b1, 1'b1, 200);
        cyc(2);
        chk("irq", 1'b1, irq);
        // sync auto: flag clears, offset steps once, status back to optimal
        sync_cfg = '{1'b1, 1'b1, 1'b0, 1'b1, 4'h0};
        cyc(80);
        chk("sync flag", 1'b0, status.sync_irq_flag);
        chk("irq", 1'b0, irq);
        chk("applied offset", 2'h2, phase_offset_applied);
        chk("phase status", lsfm_pkg::PH_OPT_HI, status.fifo_phase_status);
        $display("test sync done");
        finish_test();
    end
endmodule
